// ### src/emulated_phy_map.svh
`ifndef EMULATED_PHY_MAP_SVH
`define EMULATED_PHY_MAP_SVH

// byte offsets on the 32-bit register path
`define OFS_STATUS        12'h1c4
`define OFS_IDENT_HIGH    12'h1c8
`define OFS_IDENT_LOW     12'h1cc

// register indices on the serial management path
`define IDX_STATUS        5'h01
`define IDX_IDENT_HIGH    5'h02
`define IDX_IDENT_LOW     5'h03

// status word: abilities, link up, negotiation ability, extended capability
`define STATUS_FIXED      16'h780d
`define STATUS_ANEG_BIT   5

// lower identifier field layout
`define OUI_LOW_HI        15
`define OUI_LOW_LO        10
`define MODEL_HI          9
`define MODEL_LO          4
`define REV_HI            3
`define REV_LO            0

// emulated negotiation settling time after any reset
`define CLK_PERIOD_NS     40
`define ANEG_SETTLE_NS    1000
`define ANEG_SETTLE_CYC   ((`ANEG_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### src/emulated_phy_pkg.sv
`default_nettype none

package emulated_phy_pkg;

	// register selected by a decoded access
	typedef enum logic [3:0] {
		SEL_NONE      = 4'h1,
		SEL_STATUS    = 4'h2,
		SEL_IDENT_HIGH = 4'h4,
		SEL_IDENT_LOW = 4'h8
	} regSel_t;

	// emulated negotiation progress
	typedef enum logic [1:0] {
		ANEG_RUN  = 2'h1,
		ANEG_DONE = 2'h2
	} anegState_t;

endpackage

`default_nettype wire

// ### src/emulated_phy_status_id_regs.sv
//
// Contract
// - upper half reserved zero; serial path 16 bits
// - status bits 14..11 always read one
// - status bits 15, 10, 9 read zero
// - status bit 8 reads zero
// - status bit 6 reads zero, preamble required
// - negotiation-complete clears on reset, sets later
// - remote fault, jabber zero; link up one
// - status bit 3 reads one
// - status bit 0 reads one; registers 0-6
// - upper identifier bits 15..0 writable
// - lower identifier bits 15..10 writable OUI
// - lower identifier bits 9..4 model number
// - lower identifier bits 3..0 revision number
// - decode status, identifiers at 1C4h/1C8h/1CCh
// - soft reset restores all registers to defaults
`timescale 1ns/10ps
`default_nettype none
`include "emulated_phy_map.svh"

module emulated_phy_status_id_regs #(
	// identifier defaults: values are arbitrary
	parameter logic [15:0] IDENT_HIGH_RST = 16'h5a3c,
	parameter logic [5:0]  OUI_LOW_RST    = 6'h15,
	parameter logic [5:0]  MODEL_RST      = 6'h2a,
	parameter logic [3:0]  REV_RST        = 4'h7,
	parameter int          ANEG_CYCLES    = `ANEG_SETTLE_CYC
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        softReset,
	input  wire logic [11:0] wideAddr,
	input  wire logic        wideRead,
	input  wire logic        wideWrite,
	input  wire logic [31:0] wideWdata,
	output var  logic [31:0] wideRdata,
	output var  logic        wideAck,
	input  wire logic [4:0]  mgmtIndex,
	input  wire logic        mgmtRead,
	input  wire logic        mgmtWrite,
	input  wire logic [15:0] mgmtWdata,
	output var  logic [15:0] mgmtRdata,
	output var  logic        mgmtAck,
	output var  logic        anegComplete
);
	import emulated_phy_pkg::*;

	localparam logic [15:0] IDENT_LOW_RST =
		{OUI_LOW_RST, MODEL_RST, REV_RST};
	localparam int CNT_W = $clog2(ANEG_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(ANEG_CYCLES - 1);

	// decode of the wide path: only whole aligned slots match
	function automatic regSel_t selWide(input logic [11:0] a);
		unique case (a)
			`OFS_STATUS:     selWide = SEL_STATUS;
			`OFS_IDENT_HIGH: selWide = SEL_IDENT_HIGH;
			`OFS_IDENT_LOW:  selWide = SEL_IDENT_LOW;
			default:         selWide = SEL_NONE;
		endcase
	endfunction

	// decode of the serial management index
	function automatic regSel_t selMgmt(input logic [4:0] i);
		unique case (i)
			`IDX_STATUS:     selMgmt = SEL_STATUS;
			`IDX_IDENT_HIGH: selMgmt = SEL_IDENT_HIGH;
			`IDX_IDENT_LOW:  selMgmt = SEL_IDENT_LOW;
			default:         selMgmt = SEL_NONE;
		endcase
	endfunction

	// 16-bit read value; unmapped slots read zero
	function automatic logic [15:0] readVal(
		input regSel_t    s,
		input logic       done,
		input logic [15:0] hi,
		input logic [15:0] lo
	);
		logic [15:0] st;
		st = `STATUS_FIXED;
		st[`STATUS_ANEG_BIT] = done;
		unique case (s)
			SEL_STATUS:     readVal = st;
			SEL_IDENT_HIGH: readVal = hi;
			SEL_IDENT_LOW:  readVal = lo;
			default:        readVal = 16'h0000;
		endcase
	endfunction

	regSel_t     wSel;
	regSel_t     mSel;
	logic [15:0] identHigh_q;
	logic [15:0] identHigh_d;
	logic [15:0] identLow_q;
	logic [15:0] identLow_d;
	anegState_t  anegState_q;
	anegState_t  anegState_d;
	logic [CNT_W-1:0] anegCnt_q;
	logic [CNT_W-1:0] anegCnt_d;
	logic        anegComplete_d;
	logic [31:0] wideRdata_d;
	logic        wideAck_d;
	logic [15:0] mgmtRdata_d;
	logic        mgmtAck_d;

	assign wSel = selWide(wideAddr);
	assign mSel = selMgmt(mgmtIndex);
	// identifier storage; the wide path wins a same-cycle clash
	always_comb begin
		identHigh_d = identHigh_q;
		identLow_d  = identLow_q;
		if (mgmtWrite && mSel == SEL_IDENT_HIGH) begin
			identHigh_d = mgmtWdata;
		end
		if (mgmtWrite && mSel == SEL_IDENT_LOW) begin
			identLow_d[`OUI_LOW_HI:`OUI_LOW_LO] =
				mgmtWdata[`OUI_LOW_HI:`OUI_LOW_LO];
			identLow_d[`MODEL_HI:`MODEL_LO] =
				mgmtWdata[`MODEL_HI:`MODEL_LO];
			identLow_d[`REV_HI:`REV_LO] =
				mgmtWdata[`REV_HI:`REV_LO];
		end
		// upper wide bits are reserved and dropped here
		if (wideWrite && wSel == SEL_IDENT_HIGH) begin
			identHigh_d = wideWdata[15:0];
		end
		if (wideWrite && wSel == SEL_IDENT_LOW) begin
			identLow_d = wideWdata[15:0];
		end
		// soft reset beats any write in the same cycle
		if (softReset) begin
			identHigh_d = IDENT_HIGH_RST;
			identLow_d  = IDENT_LOW_RST;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			identHigh_q <= IDENT_HIGH_RST;
			identLow_q  <= IDENT_LOW_RST;
		end else begin
			identHigh_q <= identHigh_d;
			identLow_q  <= identLow_d;
		end
	end

	// emulated negotiation: a fixed settling delay after any reset
	always_comb begin
		anegState_d    = anegState_q;
		anegCnt_d      = anegCnt_q;
		anegComplete_d = 1'b0;
		unique case (anegState_q)
			ANEG_RUN: begin
				anegCnt_d = anegCnt_q + CNT_W'(1);
				if (anegCnt_q == CNT_LAST) begin
					anegState_d    = ANEG_DONE;
					anegComplete_d = 1'b1;
				end
			end
			ANEG_DONE: begin
				anegComplete_d = 1'b1;
			end
		endcase
		if (softReset) begin
			anegState_d    = ANEG_RUN;
			anegCnt_d      = '0;
			anegComplete_d = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			anegState_q  <= ANEG_RUN;
			anegCnt_q    <= '0;
			anegComplete <= 1'b0;
		end else begin
			anegState_q  <= anegState_d;
			anegCnt_q    <= anegCnt_d;
			anegComplete <= anegComplete_d;
		end
	end

	// read answers: registered, one cycle after the strobe
	always_comb begin
		wideAck_d   = wideRead;
		mgmtAck_d   = mgmtRead;
		wideRdata_d = wideRdata;
		mgmtRdata_d = mgmtRdata;
		if (wideRead) begin
			wideRdata_d = {16'h0000,
				readVal(wSel, anegComplete, identHigh_q, identLow_q)};
		end
		if (mgmtRead) begin
			mgmtRdata_d = readVal(mSel, anegComplete, identHigh_q,
				identLow_q);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wideRdata <= 32'h00000000;
			wideAck   <= 1'b0;
			mgmtRdata <= 16'h0000;
			mgmtAck   <= 1'b0;
		end else begin
			wideRdata <= wideRdata_d;
			wideAck   <= wideAck_d;
			mgmtRdata <= mgmtRdata_d;
			mgmtAck   <= mgmtAck_d;
		end
	end
	// helper state seen only by the checks below
	logic        mgmtStatusRd_q;
	logic [15:0] sinceReset_q;
	always_ff @(posedge clock) begin
		if (rst) begin
			mgmtStatusRd_q <= 1'b0;
			sinceReset_q   <= 16'h0000;
		end else begin
			mgmtStatusRd_q <= mgmtRead && mSel == SEL_STATUS;
			if (softReset) begin
				sinceReset_q <= 16'h0000;
			end else if (sinceReset_q != 16'hffff) begin
				sinceReset_q <= sinceReset_q + 16'h0001;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	property p_rsvd_zero;
		wideAck |-> wideRdata[31:16] == 16'h0000;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved upper half not zero");

	property p_ability_ones;
		mgmtAck && mgmtStatusRd_q |-> mgmtRdata[14:11] == 4'hf;
	endproperty
	a_ability_ones: assert property (p_ability_ones)
		else $error("ability bits not one");

	property p_unsupported_zero;
		mgmtAck && mgmtStatusRd_q |->
			!mgmtRdata[15] && mgmtRdata[10:9] == 2'h0;
	endproperty
	a_unsupported_zero: assert property (p_unsupported_zero)
		else $error("unsupported mode bit set");

	property p_ext_status_zero;
		mgmtAck && mgmtStatusRd_q |-> !mgmtRdata[8];
	endproperty
	a_ext_status_zero: assert property (p_ext_status_zero)
		else $error("extended status bit set");

	property p_preamble_zero;
		mgmtAck && mgmtStatusRd_q |-> !mgmtRdata[6];
	endproperty
	a_preamble_zero: assert property (p_preamble_zero)
		else $error("preamble suppression bit set");

	property p_aneg_settle;
		$rose(anegComplete) |->
			sinceReset_q == 16'(ANEG_CYCLES); // both move on one edge
	endproperty
	a_aneg_settle: assert property (p_aneg_settle)
		else $error("negotiation completed at wrong time");

	property p_link_fault;
		mgmtAck && mgmtStatusRd_q |->
			mgmtRdata[2] && !mgmtRdata[4] && !mgmtRdata[1]
			&& mgmtRdata[5] == $past(anegComplete);
	endproperty
	a_link_fault: assert property (p_link_fault)
		else $error("link, fault or jabber bit wrong");

	property p_aneg_ability;
		mgmtAck && mgmtStatusRd_q |-> mgmtRdata[3];
	endproperty
	a_aneg_ability: assert property (p_aneg_ability)
		else $error("negotiation ability bit clear");

	property p_ext_cap;
		mgmtAck && mgmtStatusRd_q |-> mgmtRdata[0];
	endproperty
	a_ext_cap: assert property (p_ext_cap)
		else $error("extended capability bit clear");

	property p_ident_high_wr;
		wideWrite && wideAddr == `OFS_IDENT_HIGH && !softReset |=>
			identHigh_q == $past(wideWdata[15:0]);
	endproperty
	a_ident_high_wr: assert property (p_ident_high_wr)
		else $error("upper identifier write lost");

	property p_ident_low_wr;
		mgmtWrite && mgmtIndex == `IDX_IDENT_LOW && !softReset
			&& !wideWrite ##1 !mgmtWrite && !wideWrite && !softReset
			##1 mgmtRead && mgmtIndex == `IDX_IDENT_LOW
			|=> mgmtRdata == $past(mgmtWdata, 3);
	endproperty
	a_ident_low_wr: assert property (p_ident_low_wr)
		else $error("lower identifier readback wrong");

	property p_status_decode;
		wideRead && wideAddr == `OFS_STATUS |=>
			wideAck && wideRdata[15:11] == 5'h0f && wideRdata[2];
	endproperty
	a_status_decode: assert property (p_status_decode)
		else $error("status slot not decoded");

	property p_soft_reset;
		softReset |=> identHigh_q == IDENT_HIGH_RST
			&& identLow_q == IDENT_LOW_RST && !anegComplete;
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("soft reset did not restore defaults");

	property p_status_write_ignored;
		wideWrite && wideAddr == `OFS_STATUS && !mgmtWrite
			&& !softReset |=> $stable(identHigh_q) && $stable(identLow_q);
	endproperty
	a_status_write_ignored: assert property (p_status_write_ignored)
		else $error("status write disturbed identifiers");

	c_soft_reset_done: cover property (softReset ##1 !anegComplete
		##[1:100] anegComplete);
	c_mgmt_id_write: cover property (mgmtWrite
		&& mgmtIndex == `IDX_IDENT_HIGH);
	c_wide_status: cover property (wideRead && wideAddr == `OFS_STATUS
		##1 wideAck && wideRdata[5]);
	c_unmapped: cover property (wideRead && wideAddr == 12'h1d0);

endmodule

`default_nettype wire

// ### bench/mgmt_station.sv
`timescale 1ns/10ps
`default_nettype none

// station controller model on the 16-bit index path
module mgmt_station (
	input  wire logic        clock,
	output var  logic [4:0]  mgmtIndex,
	output var  logic        mgmtRead,
	output var  logic        mgmtWrite,
	output var  logic [15:0] mgmtWdata,
	input  wire logic [15:0] mgmtRdata,
	input  wire logic        mgmtAck
);
	initial begin
		mgmtIndex = 5'h00;
		mgmtRead = 1'b0;
		mgmtWrite = 1'b0;
		mgmtWdata = 16'h0000;
	end

	// one frame: strobes held for one cycle, answer sampled on the next edge
	task automatic access(input logic wr, input logic [4:0] idx,
		input logic [15:0] wd, output logic [15:0] rd, output logic ack);
		@(posedge clock) #1;
		mgmtIndex = idx;
		mgmtRead = !wr;
		mgmtWrite = wr;
		mgmtWdata = wd;
		@(posedge clock) #1;
		ack = mgmtAck;
		rd = mgmtRdata;
		mgmtRead = 1'b0;
		mgmtWrite = 1'b0;
		// released lines must not keep showing the old value
		mgmtWdata = ~wd;
		mgmtIndex = ~idx;
	endtask
endmodule

`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "emulated_phy_map.svh"

module tb_top;
	typedef struct packed {
		logic        viaMgmt;
		logic        wr;
		logic [11:0] addr;
		logic [31:0] val;
	} rowEntry_t;

	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        softReset = 1'b0;
	logic [11:0] wideAddr = 12'h000;
	logic        wideRead = 1'b0;
	logic        wideWrite = 1'b0;
	logic [31:0] wideWdata = 32'h00000000;
	wire  [31:0] wideRdata;
	wire         wideAck;
	wire  [4:0]  mgmtIndex;
	wire         mgmtRead;
	wire         mgmtWrite;
	wire  [15:0] mgmtWdata;
	wire  [15:0] mgmtRdata;
	wire         mgmtAck;
	wire         anegComplete;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	logic [31:0] rd;
	logic        ack;

	// status: abilities 14..11, link 2, aneg ability 3, ext 0, done 5
	rowEntry_t rows [16] = '{
		'{1'b0, 1'b0, `OFS_STATUS, 32'h0000782d},
		'{1'b1, 1'b0, 12'h001, 32'h0000782d},
		'{1'b0, 1'b0, `OFS_IDENT_HIGH, 32'h00001234},
		'{1'b1, 1'b0, 12'h003, 32'h00002f19},
		'{1'b0, 1'b1, `OFS_IDENT_HIGH, 32'hffffbeef},
		'{1'b0, 1'b0, `OFS_IDENT_HIGH, 32'h0000beef},
		'{1'b1, 1'b1, 12'h003, 32'h0000a5c3},
		'{1'b1, 1'b0, 12'h003, 32'h0000a5c3},
		'{1'b0, 1'b0, `OFS_IDENT_LOW, 32'h0000a5c3},
		'{1'b0, 1'b1, `OFS_STATUS, 32'hffffffff},
		'{1'b1, 1'b1, 12'h001, 32'h00000000},
		'{1'b0, 1'b0, `OFS_STATUS, 32'h0000782d},
		'{1'b0, 1'b0, 12'h1d0, 32'h00000000},
		'{1'b1, 1'b0, 12'h004, 32'h00000000},
		'{1'b1, 1'b1, 12'h002, 32'h00000000},
		'{1'b1, 1'b0, 12'h002, 32'h00000000}
	};

	// short settle keeps the negotiation checks quick
	emulated_phy_status_id_regs #(
		.IDENT_HIGH_RST(16'h1234),
		.OUI_LOW_RST   (6'h0b),
		.MODEL_RST     (6'h31),
		.REV_RST       (4'h9),
		.ANEG_CYCLES   (4)
	) i_emulated_phy_status_id_regs (
		.clock(clock), .rst(rst), .softReset(softReset),
		.wideAddr(wideAddr), .wideRead(wideRead),
		.wideWrite(wideWrite), .wideWdata(wideWdata),
		.wideRdata(wideRdata), .wideAck(wideAck),
		.mgmtIndex(mgmtIndex), .mgmtRead(mgmtRead),
		.mgmtWrite(mgmtWrite), .mgmtWdata(mgmtWdata),
		.mgmtRdata(mgmtRdata), .mgmtAck(mgmtAck),
		.anegComplete(anegComplete)
	);

	mgmt_station i_mgmt_station (
		.clock(clock), .mgmtIndex(mgmtIndex), .mgmtRead(mgmtRead),
		.mgmtWrite(mgmtWrite), .mgmtWdata(mgmtWdata),
		.mgmtRdata(mgmtRdata), .mgmtAck(mgmtAck)
	);

	initial begin
		forever #20 clock = ~clock;
	end

	task automatic final_report();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// a hung handshake ends the run as a failure
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			final_report();
		end
	end

	task automatic cmpWord(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmpBit(input string what, input logic exp,
		input logic got);
		cmpWord(what, {31'h0, exp}, {31'h0, got});
	endtask

	// one access on either path; read data zero-extended from the index path
	task automatic doAccess(input rowEntry_t r, output logic [31:0] d,
		output logic a);
		logic [15:0] md;
		if (r.viaMgmt) begin
			i_mgmt_station.access(r.wr, r.addr[4:0], r.val[15:0], md, a);
			d = {16'h0000, md};
		end else begin
			@(posedge clock) #1;
			wideAddr = r.addr;
			wideRead = !r.wr;
			wideWrite = r.wr;
			wideWdata = r.val;
			@(posedge clock) #1;
			a = wideAck;
			d = wideRdata;
			wideRead = 1'b0;
			wideWrite = 1'b0;
			wideWdata = ~r.val;
		end
	endtask

	initial begin
		repeat (8) @(posedge clock);
		#1;
		cmpBit("anegInReset", 1'b0, anegComplete);
		cmpWord("rdataInReset", 32'h0, wideRdata);
		rst = 1'b0;
		repeat (8) @(posedge clock);
		// table of ordinary accesses on both paths
		for (int i = 0; i < 16; i++) begin
			doAccess(rows[i], rd, ack);
			cmpBit("ack", !rows[i].wr, ack);
			if (!rows[i].wr) begin
				cmpWord("rdata", rows[i].val, rd);
			end
		end
		// soft reset beats a write in the same cycle
		@(posedge clock) #1;
		softReset = 1'b1;
		wideWrite = 1'b1;
		wideAddr = `OFS_IDENT_HIGH;
		wideWdata = 32'h00001111;
		@(posedge clock) #1;
		softReset = 1'b0;
		wideWrite = 1'b0;
		cmpBit("anegAfterSoft", 1'b0, anegComplete);
		doAccess('{1'b0, 1'b0, `OFS_STATUS, 32'h0}, rd, ack);
		cmpWord("statusSettling", 32'h0000780d, rd);
		cmpBit("anegBeforeRise", 1'b0, anegComplete);
		// flag rises on the fourth edge after the soft reset edge
		@(posedge clock) #1;
		cmpBit("anegStillLow", 1'b0, anegComplete);
		@(posedge clock) #1;
		cmpBit("anegRise", 1'b1, anegComplete);
		doAccess('{1'b0, 1'b0, `OFS_IDENT_HIGH, 32'h0}, rd, ack);
		cmpWord("identHighDefault", 32'h00001234, rd);
		doAccess('{1'b1, 1'b0, 12'h003, 32'h0}, rd, ack);
		cmpWord("identLowDefault", 32'h00002f19, rd);
		// chip reset in mid-run
		@(posedge clock) #1 rst = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		cmpBit("anegMidReset", 1'b0, anegComplete);
		cmpWord("mgmtMidReset", 32'h0, {16'h0, mgmtRdata});
		rst = 1'b0;
		repeat (6) @(posedge clock);
		doAccess('{1'b1, 1'b0, 12'h001, 32'h0}, rd, ack);
		cmpWord("statusAgain", 32'h0000782d, rd);
		final_report();
	end
endmodule

`default_nettype wire
